// file: hdl/lpcs_scheduler.v
/*
 Low-power background calibration scheduler with its APB register file.
 Sleeps the offline core, wakes it, waits for settling, then asks the
 calibration engine to run. Assumes one clock (the sampling clock domain),
 a synchronous active-low reset, fuse values stable at reset release,
 and an asynchronous calibration trigger pin.
 The longest sleep code needs a 41-bit count, so the shared counter is
 that wide. A changed interval code only takes effect at the next load
 of the counter, so a running sleep or settle is never cut short.
 Read data is registered at the end of the setup cycle: the slave still
 answers with no wait state.
*/
// Function
// - sleep field 7:5 times autonomous sleep
// - sleep codes 0-3 map to counts
// - sleep codes 4-7 map; code 4 resets
// - settle field 4:3 waits after wake
// - settle codes map to counts; code 1 resets
// - trigger bit zero gives autonomous sleep
// - trigger mode sleeps while trigger high
// - enable bit gated by background enable
// - gain trim drives all cores together
// - reference trim 3:0, factory value readable
// - trims load from fuse memory
// - selector picks software bit or pin
`timescale 1ns/1ps
`include "lpcs_defines.vh"
module lpcs_scheduler #(
	parameter CNT_W = `LPCS_CNT_W
) (
	input wire clock_in,
	input wire rst_b_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	output wire [31:0] prdata_out,
	output wire pready_out,
	output wire pslverr_out,
	input wire background_cal_enable_in,
	input wire calibration_trigger_pin_in,
	input wire [7:0] fuse_gain_in,
	input wire [3:0] fuse_ref_in,
	input wire cal_done_in,
	output wire core_sleep_out,
	output wire cal_start_out,
	output wire [7:0] core_gain_adjust_out,
	output wire [3:0] reference_adjust_value_out
);
	// One-hot scheduler states; the status word shows the raw code
	localparam ST_IDLE = 5'b00001;
	localparam ST_SLEEP = 5'b00010;
	localparam ST_SETTLE = 5'b00100;
	localparam ST_CAL = 5'b01000;
	localparam ST_WAIT = 5'b10000;

	// Software-visible registers and the fuse-loaded flag
	reg [7:0] low_power_calibration_config;
	reg [7:0] core_gain_adjust;
	reg [3:0] reference_adjust_value;
	reg pin_trigger_select;
	reg software_trigger_level;
	reg fuse_loaded;

	// Trigger pin synchroniser
	reg trig_meta;
	reg trig_sync;

	// Scheduler state, read path and interval loads
	reg [4:0] state;
	reg [4:0] next_state;
	reg [31:0] rdata;
	reg [31:0] prdata;
	reg cal_start;
	reg core_sleep;
	reg [CNT_W-1:0] sleep_len;
	reg [CNT_W-1:0] settle_len;
	reg [CNT_W-1:0] cnt_len;
	reg cnt_start;

	// Decode and control wires
	wire cnt_busy;
	wire cnt_done;
	wire [9:0] word_idx;
	wire sel_cfg;
	wire sel_gain;
	wire sel_ref;
	wire sel_trig;
	wire sel_soft;
	wire sel_stat;
	wire [6:0] status_bits;
	wire addr_ok;
	wire wr_en;
	wire [2:0] sleep_interval_sel;
	wire [1:0] settle_interval_sel;
	wire trigger_driven_sleep;
	wire low_power_cal_enable;
	wire active;
	wire eff_trigger;

	assign sleep_interval_sel =
		low_power_calibration_config[`LPCS_SLEEP_HI:`LPCS_SLEEP_LO];
	assign settle_interval_sel =
		low_power_calibration_config[`LPCS_SETTLE_HI:`LPCS_SETTLE_LO];
	assign trigger_driven_sleep = low_power_calibration_config[`LPCS_TRIG_BIT];
	assign low_power_cal_enable = low_power_calibration_config[`LPCS_EN_BIT];
	// Low-power mode only counts while background calibration runs
	assign active = low_power_cal_enable && background_cal_enable_in;

	// Two-flop synchroniser for the trigger pin
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
		end
		else
		begin
			trig_meta <= calibration_trigger_pin_in;
			trig_sync <= trig_meta;
		end
	end

	// Source select: the unused source is ignored entirely
	assign eff_trigger = pin_trigger_select ? trig_sync : software_trigger_level;

	// APB decode: word-aligned byte address, index = byte address / 4
	assign word_idx = paddr_in[11:2];
	assign sel_cfg = (word_idx == {2'h0, `LPCS_IDX_LP_CFG});
	assign sel_gain = (word_idx == {2'h0, `LPCS_IDX_GAIN});
	assign sel_ref = (word_idx == {2'h0, `LPCS_IDX_REF});
	assign sel_trig = (word_idx == {2'h0, `LPCS_IDX_TRIG});
	assign sel_soft = (word_idx == {2'h0, `LPCS_IDX_SOFT});
	assign sel_stat = (word_idx == {2'h0, `LPCS_IDX_STAT});
	// Unmapped words answer with an error and change nothing
	assign addr_ok = sel_cfg || sel_gain || sel_ref || sel_trig || sel_soft || sel_stat;
	assign wr_en = psel_in && penable_in && pwrite_in && pstrb_in[0];
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !addr_ok;

	// Control registers; a write in the fuse-copy cycle is dropped like the trims
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			low_power_calibration_config <= `LPCS_LP_CFG_RST;
			pin_trigger_select <= `LPCS_TRIG_RST;
			software_trigger_level <= `LPCS_SOFT_RST;
		end
		else if (wr_en && fuse_loaded)
		begin
			if (sel_cfg)
				low_power_calibration_config <= pwdata_in[7:0];
			if (sel_trig)
				pin_trigger_select <= pwdata_in[0];
			if (sel_soft)
				software_trigger_level <= pwdata_in[0];
		end
	end

	// Trims: loaded from fuses in the cycle after reset, then software owned
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			core_gain_adjust <= `LPCS_GAIN_RST;
			reference_adjust_value <= `LPCS_REF_RST;
			fuse_loaded <= 1'b0;
		end
		else if (!fuse_loaded)
		begin
			// Fuse copy wins over any early write so factory value is seen first
			core_gain_adjust <= fuse_gain_in;
			reference_adjust_value <= fuse_ref_in;
			fuse_loaded <= 1'b1;
		end
		else if (wr_en)
		begin
			if (sel_gain)
				core_gain_adjust <= pwdata_in[7:0];
			if (sel_ref)
				reference_adjust_value <= pwdata_in[`LPCS_REF_HI:0];
		end
	end

	// Read mux; reserved reference bits read zero
	always @*
	begin
		rdata = 32'h00000000;
		case (word_idx)
			{2'h0, `LPCS_IDX_LP_CFG}: rdata = {24'h000000, low_power_calibration_config};
			{2'h0, `LPCS_IDX_GAIN}: rdata = {24'h000000, core_gain_adjust};
			{2'h0, `LPCS_IDX_REF}: rdata = {28'h0000000, reference_adjust_value};
			{2'h0, `LPCS_IDX_TRIG}: rdata = {31'h00000000, pin_trigger_select};
			{2'h0, `LPCS_IDX_SOFT}: rdata = {31'h00000000, software_trigger_level};
			{2'h0, `LPCS_IDX_STAT}: rdata = {25'h0, status_bits};
			default: rdata = 32'h00000000;
		endcase
	end

	// Status word: counter running, effective trigger, raw one-hot state
	assign status_bits = {cnt_busy, eff_trigger, state};

	// Read data captured at the end of setup; a flop, not the mux, drives the bus
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			prdata <= 32'h00000000;
		end
		else if (psel_in && !penable_in)
		begin
			// Writes return zero so stale read data never lingers on the bus
			prdata <= pwrite_in ? 32'h00000000 : rdata;
		end
		else if (!psel_in)
		begin
			prdata <= 32'h00000000;
		end
	end
	assign prdata_out = prdata;

	// Sleep code to count
	always @*
	begin
		case (sleep_interval_sel)
			3'h0: sleep_len = `LPCS_SLP0;
			3'h1: sleep_len = `LPCS_SLP1;
			3'h2: sleep_len = `LPCS_SLP2;
			3'h3: sleep_len = `LPCS_SLP3;
			3'h4: sleep_len = `LPCS_SLP4;
			3'h5: sleep_len = `LPCS_SLP5;
			3'h6: sleep_len = `LPCS_SLP6;
			default: sleep_len = `LPCS_SLP7;
		endcase
	end

	// Settle code to count
	always @*
	begin
		case (settle_interval_sel)
			2'h0: settle_len = `LPCS_SET0;
			2'h1: settle_len = `LPCS_SET1;
			2'h2: settle_len = `LPCS_SET2;
			default: settle_len = `LPCS_SET3;
		endcase
	end

	// One shared counter: sleep and settle never overlap
	lpcs_interval_counter #(
		.W(CNT_W)
	) u_counter (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.start_in(cnt_start),
		.abort_in(!active),
		.length_in(cnt_len),
		.busy_out(cnt_busy),
		.done_out(cnt_done)
	);

	// Scheduler next state and counter loads
	always @*
	begin
		next_state = state;
		cnt_start = 1'b0;
		cnt_len = sleep_len;
		case (state)
			ST_IDLE:
			begin
				if (active)
				begin
					next_state = ST_SLEEP;
					if (!trigger_driven_sleep)
						cnt_start = 1'b1;
				end
			end
			ST_SLEEP:
			begin
				// Trigger mode ignores the sleep count and waits for trigger low
				if (trigger_driven_sleep ? !eff_trigger : cnt_done)
				begin
					next_state = ST_SETTLE;
					cnt_start = 1'b1;
					cnt_len = settle_len;
				end
			end
			ST_SETTLE:
			begin
				if (cnt_done)
					next_state = ST_CAL;
			end
			// One cycle only: the start pulse is registered from next_state, so it is high in this state
			ST_CAL:
				next_state = ST_WAIT;
			ST_WAIT:
			begin
				// The engine may take as long as it needs; no timeout here
				if (cal_done_in)
				begin
					next_state = ST_SLEEP;
					if (!trigger_driven_sleep)
						cnt_start = 1'b1;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
		// Leaving low-power mode drops everything back to idle
		if (!active)
		begin
			next_state = ST_IDLE;
			cnt_start = 1'b0;
		end
	end

	// State register and registered calibration start pulse
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			state <= ST_IDLE;
			cal_start <= 1'b0;
			core_sleep <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cal_start <= (next_state == ST_CAL);
			core_sleep <= (next_state == ST_SLEEP);
		end
	end

	assign core_sleep_out = core_sleep;
	assign cal_start_out = cal_start;
	assign core_gain_adjust_out = core_gain_adjust;
	assign reference_adjust_value_out = reference_adjust_value;
endmodule

// file: hdl/lpcs_defines.vh
/*
 Constants for the low-power background calibration scheduler:
 register offsets, field positions, reset values and interval counts.
 Assumes inclusion by bare name from the design and verification files.
*/
`ifndef LPCS_DEFINES_VH
`define LPCS_DEFINES_VH

// Printed offsets are not all multiples of four: index, byte address = 4 x index
`define LPCS_IDX_LP_CFG 8'h6e
`define LPCS_IDX_GAIN 8'h7a
`define LPCS_IDX_REF 8'h7c
`define LPCS_IDX_TRIG 8'h6b
`define LPCS_IDX_SOFT 8'h6c
`define LPCS_IDX_STAT 8'h6d

// Field positions of the low-power config register and the reference trim
`define LPCS_SLEEP_HI 7
`define LPCS_SLEEP_LO 5
`define LPCS_SETTLE_HI 4
`define LPCS_SETTLE_LO 3
`define LPCS_RSVD_BIT 2
`define LPCS_TRIG_BIT 1
`define LPCS_EN_BIT 0
`define LPCS_REF_HI 3

// Reset values
`define LPCS_LP_CFG_RST 8'h88
`define LPCS_TRIG_RST 1'h0
`define LPCS_SOFT_RST 1'h1
`define LPCS_GAIN_RST 8'h00
`define LPCS_REF_RST 4'h0

// Interval counts in sampling-clock periods; code 7 needs bit 40
`define LPCS_CNT_W 41
`define LPCS_SLP0 41'h00000000480
`define LPCS_SLP1 41'h00000400080
`define LPCS_SLP2 41'h00002000080
`define LPCS_SLP3 41'h00010000080
`define LPCS_SLP4 41'h00080000080
`define LPCS_SLP5 41'h00400000080
`define LPCS_SLP6 41'h02000000080
`define LPCS_SLP7 41'h10000000080
`define LPCS_SET0 41'h00000000480
`define LPCS_SET1 41'h00002000080
`define LPCS_SET2 41'h00010000080
`define LPCS_SET3 41'h00080000080

`endif

// file: hdl/lpcs_interval_counter.v
/*
 Down counter for one interval: loads on start, flags done at terminal
 count. Assumes start is a one-cycle pulse on clock_in.
*/
`timescale 1ns/1ps
module lpcs_interval_counter #(
	parameter W = 40
) (
	input wire clock_in,
	input wire rst_b_in,
	input wire start_in,
	input wire abort_in,
	input wire [W-1:0] length_in,
	output wire busy_out,
	output wire done_out
);
	reg [W-1:0] remaining;
	reg running;

	// One step per sampling-clock period
	always @(posedge clock_in)
	begin
		if (!rst_b_in || abort_in)
		begin
			remaining <= {W{1'b0}};
			running <= 1'b0;
		end
		else if (start_in)
		begin
			remaining <= length_in - {{(W-1){1'b0}}, 1'b1};
			running <= 1'b1;
		end
		else if (running)
		begin
			remaining <= remaining - {{(W-1){1'b0}}, 1'b1};
			if (remaining == {W{1'b0}})
				running <= 1'b0;
		end
	end

	assign busy_out = running;
	assign done_out = running && (remaining == {W{1'b0}});
endmodule

// file: verification/lpcs_scheduler_props.sv
/* Port checker for the calibration scheduler.
 Assumes binding to lpcs_scheduler, one clock, sync active-low reset. */
`timescale 1ns/1ps
`include "lpcs_defines.vh"
module lpcs_sched_props #(
	parameter CNT_W = 41
) (
	input wire clock_in,
	input wire rst_b_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	input wire [31:0] prdata_out,
	input wire background_cal_enable_in,
	input wire [7:0] fuse_gain_in,
	input wire [3:0] fuse_ref_in,
	input wire core_sleep_out,
	input wire cal_start_out,
	input wire [7:0] core_gain_adjust_out,
	input wire [3:0] reference_adjust_value_out
);
	// Access phase and trim byte addresses
	wire acc = psel_in && penable_in && pwrite_in && pstrb_in[0];
	wire [11:0] a_gain = {2'h0, `LPCS_IDX_GAIN, 2'h0};
	wire [11:0] a_ref = {2'h0, `LPCS_IDX_REF, 2'h0};
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);
	// Writes on the first edge after reset are dropped, hence the $past
	sequence gain_wr;
		acc && paddr_in == a_gain && $past(rst_b_in);
	endsequence
	sequence ref_wr;
		acc && paddr_in == a_ref && $past(rst_b_in);
	endsequence
	sequence rst_rel;
		$rose(rst_b_in);
	endsequence
	fuse_load_a: assert property (rst_rel |=> core_gain_adjust_out == $past(fuse_gain_in)
		&& reference_adjust_value_out == $past(fuse_ref_in)) else $error("fuse load");
	gain_write_a: assert property (gain_wr |=>
		core_gain_adjust_out == $past(pwdata_in[7:0])) else $error("gain write");
	ref_write_a: assert property (ref_wr |=>
		reference_adjust_value_out == $past(pwdata_in[3:0])) else $error("ref write");
	gain_read_a: assert property (psel_in && penable_in && !pwrite_in && paddr_in == a_gain
		|-> prdata_out == {24'h0, core_gain_adjust_out}) else $error("gain read");
	start_pulse_a: assert property (cal_start_out |=> !cal_start_out)
		else $error("start not a pulse");
	awake_cal_a: assert property (cal_start_out |-> !core_sleep_out
		&& !$past(core_sleep_out)) else $error("cal without settle");
	enable_gate_a: assert property (!background_cal_enable_in |=>
		!core_sleep_out && !cal_start_out) else $error("active while disabled");
	wake_settle_a: assert property ($fell(core_sleep_out) |-> !cal_start_out[*8])
		else $error("settle too short");
endmodule
bind lpcs_scheduler lpcs_sched_props #(.CNT_W(CNT_W)) i_lpcs_sched_props (
	.clock_in(clock_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
	.background_cal_enable_in(background_cal_enable_in), .fuse_gain_in(fuse_gain_in),
	.fuse_ref_in(fuse_ref_in), .core_sleep_out(core_sleep_out), .cal_start_out(cal_start_out),
	.core_gain_adjust_out(core_gain_adjust_out),
	.reference_adjust_value_out(reference_adjust_value_out));

// file: verification/lpcs_host_model.sv
/* Host model: drives the trigger pin and answers each calibration
 start with a done pulse after a delay. Assumes the scheduler clock. */
`timescale 1ns/1ps
module lpcs_host_model (
	input wire clock_in,
	input wire cal_start_in,
	input wire [7:0] done_delay_in,
	input wire trig_req_in,
	output reg cal_done_out = 1'b0,
	output reg trig_pin_out = 1'b0
);
	reg [7:0] cnt = 8'h0;
	reg busy = 1'b0;
	// Delay zero answers on the clock after the start, larger values stall the scheduler
	always @(posedge clock_in)
	begin
		trig_pin_out <= trig_req_in;
		cal_done_out <= 1'b0;
		if (cal_start_in)
		begin
			busy <= 1'b1;
			cnt <= done_delay_in;
		end
		else if (busy && cnt == 8'h0)
		begin
			busy <= 1'b0;
			cal_done_out <= 1'b1;
		end
		else if (busy)
			cnt <= cnt - 8'h1;
	end
endmodule

// file: verification/lpcs_scheduler_tb.sv
/* Self-checking bench for the calibration scheduler.
 Assumes the host model on the trigger pin and done lines. */
`timescale 1ns/1ps
`include "lpcs_defines.vh"
module lpcs_scheduler_tb;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, bg_en = 0, treq = 0;
	logic pin, done, sleep, start, pready, e, rerr;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] gain, dly = 8'h14;
	logic [3:0] ref_v;
	int err_count = 0, n_compared = 0, n;
	// 200 MHz sampling clock
	always #2.5 clk = ~clk;
	lpcs_scheduler i_lpcs_scheduler (.clock_in(clk), .rst_b_in(rst_b), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.pstrb_in(4'h1), .prdata_out(prdata), .pready_out(pready), .pslverr_out(e),
		.background_cal_enable_in(bg_en), .calibration_trigger_pin_in(pin),
		.fuse_gain_in(8'ha5), .fuse_ref_in(4'h6), .cal_done_in(done), .core_sleep_out(sleep),
		.cal_start_out(start), .core_gain_adjust_out(gain), .reference_adjust_value_out(ref_v));
	lpcs_host_model i_lpcs_host_model (.clock_in(clk), .cal_start_in(start),
		.done_delay_in(dly), .trig_req_in(treq), .cal_done_out(done), .trig_pin_out(pin));
	task chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	// One APB transfer; held until pready is seen high
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		rerr = e;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Cycles spent at one sleep level before the level or start changes
	task span(input logic lvl);
		n = 0;
		while (n < 5000 && sleep === lvl && start !== 1'b1)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task wait_sleep;
		while (sleep !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task t_regs;
		apb(0, `LPCS_IDX_LP_CFG, 0);
		chk(rd, 32'h88);
		apb(0, `LPCS_IDX_GAIN, 0);
		chk(rd, 32'ha5);
		apb(0, `LPCS_IDX_REF, 0);
		chk(rd, 32'h6);
		apb(1, `LPCS_IDX_GAIN, 32'h3c);
		apb(0, `LPCS_IDX_GAIN, 0);
		chk(rd, 32'h3c);
		chk(gain, 8'h3c);
		apb(1, `LPCS_IDX_REF, 32'h09);
		#1;
		chk(ref_v, 4'h9);
		apb(0, 8'h01, 0);
		chk(rerr, 1);
		$display("test regs done");
	endtask
	task t_auto;
		bg_en <= 1'b1;
		apb(1, `LPCS_IDX_LP_CFG, 32'h01);
		wait_sleep;
		span(1);
		chk(n, 1152);
		span(0);
		chk(n, 1152);
		chk(start, 1);
		dly <= 8'h0;
		wait_sleep;
		span(1);
		chk(n, 1152);
		wait_sleep;
		repeat (100) @(posedge clk);
		bg_en <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(sleep, 0);
		$display("test auto done");
	endtask
	// Soft path first, then pin path; code 0 sleep would end at 1152
	task t_trig;
		@(posedge clk);
		bg_en <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			treq <= p[0];
			apb(1, `LPCS_IDX_TRIG, p);
			apb(1, `LPCS_IDX_SOFT, p == 0);
			apb(1, `LPCS_IDX_LP_CFG, 32'h03);
			wait_sleep;
			repeat (1500) @(posedge clk);
			#1;
			chk(sleep, 1);
			@(posedge clk);
			treq <= 1'b0;
			apb(1, `LPCS_IDX_SOFT, 0);
			span(1);
			chk(n < 20, 1);
		end
		// Back to idle trigger setup and the recommended interval codes
		apb(1, `LPCS_IDX_TRIG, 0);
		apb(1, `LPCS_IDX_SOFT, 1);
		apb(1, `LPCS_IDX_LP_CFG, 32'h89);
		wait_sleep;
		repeat (1500) @(posedge clk);
		#1;
		chk(sleep, 1);
		apb(0, `LPCS_IDX_STAT, 0);
		chk(rd[6:0], 7'h62);
		$display("test trig done");
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs;
		t_auto;
		t_trig;
		give_verdict;
	end
	// Watchdog: the tests need about 12k cycles, limit 30k
	initial
	begin
		#150000;
		err_count++;
		give_verdict;
	end
endmodule
